// [hw/qsp_defines.svh]
// Constants for the quad serial port glue: address map, switch codes and clock rates.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef QSP_DEFINES_SVH
`define QSP_DEFINES_SVH

`define QSP_NUM_PORTS      4
`define QSP_ADDR_W         10
`define QSP_IRQ_LINES      16
`define QSP_IRQ_SEL_W      4
`define QSP_PORT_SPAN_BITS 3
`define QSP_LEGACY_BASE1   10'h3f8
`define QSP_LEGACY_BASE2   10'h2f8
`define QSP_LEGACY_BASE3   10'h3e8
`define QSP_LEGACY_BASE4   10'h2e8
`define QSP_REL_PORT_OFS1  5'h00
`define QSP_REL_PORT_OFS2  5'h08
`define QSP_REL_PORT_OFS3  5'h10
`define QSP_REL_PORT_OFS4  5'h18
`define QSP_WINDOW_BITS    5
`define QSP_REL_BASE_MIN   10'h200
`define QSP_MODE_IRQ_BIT   0
`define QSP_MODE_MAP_BIT   1
`define QSP_SYS_CLK_HZ     125000000
`define QSP_REF_FAST_HZ    14745600
`define QSP_REF_SLOW_HZ    1843200
`define QSP_NCO_BITS       24
`define QSP_HOLD_W         16

`endif

// [hw/qsp_pkg.sv]
// Types shared by the quad serial port glue modules.
// Assumes qsp_defines.svh is on the include path.
`include "qsp_defines.svh"

package qsp_pkg;

    // Driver-enable jumper codes.
    typedef enum logic [1:0] {
        QSP_DE_AUTO = 2'h0,
        QSP_DE_RTS  = 2'h1,
        QSP_DE_ON   = 2'h2
    } qsp_de_mode_t;

    // Direction state of one port in automatic mode.
    typedef enum logic [1:0] {
        QSP_DIR_RX = 2'h1,
        QSP_DIR_TX = 2'h2
    } qsp_dir_state_t;

    // Every input from outside the clock domain except autoHoldTicks, synchronised as one word.
    typedef struct packed {
        logic                                          ioRdN;
        logic                                          ioWrN;
        logic [`QSP_NUM_PORTS-1:0]                     uartTxd;
        logic [`QSP_NUM_PORTS-1:0]                     lineRxd;
        logic                                          ioAen;
        logic [`QSP_ADDR_W-1:0]                        ioAddr;
        logic [`QSP_NUM_PORTS-1:0]                     uartRts;
        logic                                          speedSwitch;
        logic [1:0]                                    modeSwitch;
        logic [4:0]                                    baseSwitch;
        logic [`QSP_NUM_PORTS-1:0][1:0]                deJumper;
        logic [`QSP_NUM_PORTS-1:0][`QSP_IRQ_SEL_W-1:0] irqSel;
        logic [`QSP_NUM_PORTS-1:0]                     uartIrq;
    } qsp_pins_t;

    // Line side of one port.
    typedef struct packed {
        logic txOut;
        logic txOe;
        logic rxToUart;
    } qsp_line_t;

endpackage : qsp_pkg

// [hw/qsp_addr_decode.sv]
// Host I/O address decoder for the four UART chip selects.
// Assumes synchronised address, address-enable and switch inputs on the same clock.
`timescale 1ns/1ps
`include "qsp_defines.svh"

module qsp_addr_decode
    import qsp_pkg::*;
(
    input  wire logic [`QSP_ADDR_W-1:0]    addr,
    input  wire logic                      aen,
    input  wire logic                      legacyMap,
    input  wire logic [4:0]                baseSwitch,
    output logic      [`QSP_NUM_PORTS-1:0] portHit
);

    // True when both addresses fall in the same eight-byte port block.
    function automatic logic sameBlock(input logic [`QSP_ADDR_W-1:0] a,
                                       input logic [`QSP_ADDR_W-1:0] b);
        sameBlock = (a[`QSP_ADDR_W-1:`QSP_PORT_SPAN_BITS] == b[`QSP_ADDR_W-1:`QSP_PORT_SPAN_BITS]);
    endfunction : sameBlock

    // A closed switch reads as one and clears its base bit.
    wire logic [`QSP_ADDR_W-1:0] relBase = `QSP_REL_BASE_MIN
                                         | {1'b0, ~baseSwitch[4], ~baseSwitch[3:0], 4'h0};
    wire logic [`QSP_ADDR_W-1:0] legacyBase [`QSP_NUM_PORTS];
    wire logic [`QSP_WINDOW_BITS-1:0] relOfs [`QSP_NUM_PORTS];

    assign legacyBase[0] = `QSP_LEGACY_BASE1;
    assign legacyBase[1] = `QSP_LEGACY_BASE2;
    assign legacyBase[2] = `QSP_LEGACY_BASE3;
    assign legacyBase[3] = `QSP_LEGACY_BASE4;
    assign relOfs[0]     = `QSP_REL_PORT_OFS1;
    assign relOfs[1]     = `QSP_REL_PORT_OFS2;
    assign relOfs[2]     = `QSP_REL_PORT_OFS3;
    assign relOfs[3]     = `QSP_REL_PORT_OFS4;

    for (genvar p = 0; p < `QSP_NUM_PORTS; p++) begin : g_port
        wire logic [`QSP_ADDR_W-1:0] relPortBase = relBase
                                                 + {{(`QSP_ADDR_W-`QSP_WINDOW_BITS){1'b0}}, relOfs[p]};
        wire logic legacyHit = sameBlock(addr, legacyBase[p]);
        wire logic relHit    = sameBlock(addr, relPortBase);
        assign portHit[p] = !aen && (legacyMap ? legacyHit : relHit);
    end

endmodule : qsp_addr_decode

// [hw/qsp_dir_ctrl.sv]
// Line-driver direction control for one serial port.
// Assumes synchronised TXD and RTS and a reference tick enable on the same clock.
`timescale 1ns/1ps
`include "qsp_defines.svh"

module qsp_dir_ctrl
    import qsp_pkg::*;
#(
    parameter int HOLD_W = `QSP_HOLD_W
)
(
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              refTick,
    input  wire logic [1:0]        deMode,
    input  wire logic              txd,
    input  wire logic              rts,
    input  wire logic [HOLD_W-1:0] holdTicks,
    output logic                   drvEn,
    output logic                   rxMask
);

    qsp_dir_state_t    state;
    qsp_dir_state_t    next_state;
    logic [HOLD_W-1:0] idleCnt;
    logic [HOLD_W-1:0] next_idleCnt;

    wire logic modeAuto = (deMode == QSP_DE_AUTO);
    wire logic modeRts  = (deMode == QSP_DE_RTS);
    wire logic modeOn   = (deMode == QSP_DE_ON);
    wire logic holdDone = (idleCnt >= holdTicks);

    // A low TXD is a start bit or data; the driver stays on until the line has idled
    // high for the hold time, which must cover the last stop bit at the chosen baud.
    always_comb begin
        next_state   = state;
        next_idleCnt = idleCnt;
        case (state)
            QSP_DIR_RX: begin
                next_idleCnt = '0;
                if (modeAuto && !txd) begin
                    next_state = QSP_DIR_TX;
                end
            end
            QSP_DIR_TX: begin
                if (!modeAuto) begin
                    next_state = QSP_DIR_RX;
                end else if (!txd) begin
                    next_idleCnt = '0;
                end else if (holdDone) begin
                    next_state = QSP_DIR_RX;
                end else if (refTick) begin
                    next_idleCnt = idleCnt + 1'b1;
                end
            end
            default: begin
                next_state   = QSP_DIR_RX;
                next_idleCnt = '0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state   <= QSP_DIR_RX;
            idleCnt <= '0;
        end else begin
            state   <= next_state;
            idleCnt <= next_idleCnt;
        end
    end

    // Auto follows direction, RTS gates the driver, ON drives permanently.
    assign drvEn = (modeAuto && state == QSP_DIR_TX)
                || (modeRts && rts)
                || modeOn;
    // Half-duplex modes hide the local echo from the receiver while driving.
    assign rxMask = drvEn && !modeOn;

endmodule : qsp_dir_ctrl

// [hw/qsp_card.sv]
// Top of the quad serial port glue: host decode, interrupt routing, reference clock
// enable and per-port line-driver control.
// Assumes external UARTs and line transceivers; all pins are asynchronous to clk.
//
// Functional notes
// - In two-wire mode the driver turns around itself, no handshake or software.
// - Half duplex: never drive the shared pair while receiving.
// - Each port has its own driver mode; auto follows detected data direction.
// - RTS mode enables the driver only while the UART RTS output is high.
// - RTS mode with RTS low leaves the driver output in high impedance.
// - ON mode keeps the driver permanently enabled, for four-wire full duplex.
// - Interrupt switch on: all ports share port 1 line; off: own lines.
// - Map switch on selects the fixed legacy map, off the relocatable window.
// - Legacy map places ports at 3F8h, 2F8h, 3E8h, 2E8h, eight bytes each.
// - Relocatable map: 32-byte window, ports at base plus 00h, 08h, 10h, 18h.
// - Speed switch on gives 14.7456 MHz reference, off gives 1.8432 MHz.
`timescale 1ns/1ps
`include "qsp_defines.svh"

module qsp_card
    import qsp_pkg::*;
#(
    parameter int NUM_PORTS = `QSP_NUM_PORTS,
    parameter int IRQ_LINES = `QSP_IRQ_LINES,
    parameter int NCO_BITS  = `QSP_NCO_BITS,
    parameter int HOLD_W    = `QSP_HOLD_W
)
(
    input  wire logic                                   clk,
    input  wire logic                                   nrst,
    input  wire logic [`QSP_ADDR_W-1:0]                 ioAddr,
    input  wire logic                                   ioAen,
    input  wire logic                                   ioRdN,
    input  wire logic                                   ioWrN,
    input  wire logic                                   speed_switch_bank,
    input  wire logic [1:0]                             mode_switch_bank,
    input  wire logic [4:0]                             baseAddrSwitch,
    input  wire logic [1:0]                             port1_driver_enable_jumper,
    input  wire logic [1:0]                             port2_driver_enable_jumper,
    input  wire logic [1:0]                             port3_driver_enable_jumper,
    input  wire logic [1:0]                             port4_driver_enable_jumper,
    input  wire logic [`QSP_IRQ_SEL_W-1:0]              port1_irq_line_select,
    input  wire logic [`QSP_IRQ_SEL_W-1:0]              port2_irq_line_select,
    input  wire logic [`QSP_IRQ_SEL_W-1:0]              port3_irq_line_select,
    input  wire logic [`QSP_IRQ_SEL_W-1:0]              port4_irq_line_select,
    input  wire logic [HOLD_W-1:0]                      autoHoldTicks,
    input  wire logic [NUM_PORTS-1:0]                   uartTxd,
    input  wire logic [NUM_PORTS-1:0]                   uartRts,
    input  wire logic [NUM_PORTS-1:0]                   uartIrq,
    input  wire logic [NUM_PORTS-1:0]                   lineRxd,
    output logic      [NUM_PORTS-1:0]                   uartSel,
    output logic                                        uartRdStb,
    output logic                                        uartWrStb,
    output logic                                        cardHit,
    output logic                                        uartRefTick,
    output logic      [IRQ_LINES-1:0]                   irqOut,
    output logic      [NUM_PORTS-1:0]                   lineTxOut,
    output logic      [NUM_PORTS-1:0]                   lineTxOe,
    output logic      [NUM_PORTS-1:0]                   uartRxd
);

    localparam int PINS_W = $bits(qsp_pins_t);
    localparam int HI_W   = 2 + 2 * `QSP_NUM_PORTS;

    // Idle-high inputs reset high so that no strobe or start bit appears at release.
    localparam logic [PINS_W-1:0] PINS_RST = {{HI_W{1'b1}}, {(PINS_W-HI_W){1'b0}}};

    localparam logic [63:0] SYS_HZ64 = 64'(`QSP_SYS_CLK_HZ);
    localparam logic [NCO_BITS-1:0] INC_FAST =
        NCO_BITS'((64'(`QSP_REF_FAST_HZ) << NCO_BITS) / SYS_HZ64);
    localparam logic [NCO_BITS-1:0] INC_SLOW =
        NCO_BITS'((64'(`QSP_REF_SLOW_HZ) << NCO_BITS) / SYS_HZ64);

    // Two-stage synchroniser for every pin input except autoHoldTicks.
    qsp_pins_t pinsRaw;
    qsp_pins_t pinsMeta;
    qsp_pins_t pins;

    assign pinsRaw.ioRdN       = ioRdN;
    assign pinsRaw.ioWrN       = ioWrN;
    assign pinsRaw.uartTxd     = uartTxd;
    assign pinsRaw.lineRxd     = lineRxd;
    assign pinsRaw.ioAen       = ioAen;
    assign pinsRaw.ioAddr      = ioAddr;
    assign pinsRaw.uartRts     = uartRts;
    assign pinsRaw.speedSwitch = speed_switch_bank;
    assign pinsRaw.modeSwitch  = mode_switch_bank;
    assign pinsRaw.baseSwitch  = baseAddrSwitch;
    assign pinsRaw.deJumper[0] = port1_driver_enable_jumper;
    assign pinsRaw.deJumper[1] = port2_driver_enable_jumper;
    assign pinsRaw.deJumper[2] = port3_driver_enable_jumper;
    assign pinsRaw.deJumper[3] = port4_driver_enable_jumper;
    assign pinsRaw.irqSel[0]   = port1_irq_line_select;
    assign pinsRaw.irqSel[1]   = port2_irq_line_select;
    assign pinsRaw.irqSel[2]   = port3_irq_line_select;
    assign pinsRaw.irqSel[3]   = port4_irq_line_select;
    assign pinsRaw.uartIrq     = uartIrq;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pinsMeta <= qsp_pins_t'(PINS_RST);
            pins     <= qsp_pins_t'(PINS_RST);
        end else begin
            pinsMeta <= pinsRaw;
            pins     <= pinsMeta;
        end
    end

    // Host address decode.
    wire logic legacyMap   = pins.modeSwitch[`QSP_MODE_MAP_BIT];
    wire logic sharedIrq   = pins.modeSwitch[`QSP_MODE_IRQ_BIT];
    wire logic hostRd      = !pins.ioRdN;
    wire logic hostWr      = !pins.ioWrN;
    wire logic hostStrobe  = hostRd || hostWr;
    logic [NUM_PORTS-1:0] portHit;

    qsp_addr_decode u_decode (
        .addr       (pins.ioAddr),
        .aen        (pins.ioAen),
        .legacyMap  (legacyMap),
        .baseSwitch (pins.baseSwitch),
        .portHit    (portHit)
    );

    // Chip selects qualify the decode with an active strobe; a write with a read
    // at once is ignored as a bus fault.
    wire logic strobeOk = hostStrobe && !(hostRd && hostWr);
    wire logic [NUM_PORTS-1:0] next_uartSel = strobeOk ? portHit : '0;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            uartSel   <= '0;
            uartRdStb <= 1'b0;
            uartWrStb <= 1'b0;
            cardHit   <= 1'b0;
        end else begin
            uartSel   <= next_uartSel;
            uartRdStb <= strobeOk && hostRd && (|portHit);
            uartWrStb <= strobeOk && hostWr && (|portHit);
            cardHit   <= |next_uartSel;
        end
    end

    // Reference clock enable from a phase accumulator; the carry marks each tick.
    logic [NCO_BITS-1:0] ncoAcc;
    wire logic [NCO_BITS-1:0] ncoInc = pins.speedSwitch ? INC_FAST : INC_SLOW;
    wire logic [NCO_BITS:0]   ncoSum = {1'b0, ncoAcc} + {1'b0, ncoInc};

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ncoAcc      <= '0;
            uartRefTick <= 1'b0;
        end else begin
            ncoAcc      <= ncoSum[NCO_BITS-1:0];
            uartRefTick <= ncoSum[NCO_BITS];
        end
    end

    // Interrupt routing onto the host lines.
    function automatic logic routesTo(input logic [`QSP_IRQ_SEL_W-1:0] sel,
                                      input logic [`QSP_IRQ_SEL_W-1:0] line);
        routesTo = (sel == line);
    endfunction : routesTo

    logic [IRQ_LINES-1:0] next_irqOut;

    for (genvar l = 0; l < IRQ_LINES; l++) begin : g_irq
        wire logic [`QSP_IRQ_SEL_W-1:0] lineId = `QSP_IRQ_SEL_W'(l);
        wire logic [NUM_PORTS-1:0] srcHit;
        for (genvar p = 0; p < NUM_PORTS; p++) begin : g_src
            wire logic [`QSP_IRQ_SEL_W-1:0] selUsed = sharedIrq ? pins.irqSel[0]
                                                                : pins.irqSel[p];
            assign srcHit[p] = pins.uartIrq[p] && routesTo(selUsed, lineId);
        end
        assign next_irqOut[l] = |srcHit;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            irqOut <= '0;
        end else begin
            irqOut <= next_irqOut;
        end
    end

    // Per-port line driver control.
    logic [NUM_PORTS-1:0] drvEn;
    logic [NUM_PORTS-1:0] rxMask;

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_line
        qsp_dir_ctrl #(
            .HOLD_W (HOLD_W)
        ) u_dir (
            .clk       (clk),
            .nrst      (nrst),
            .refTick   (uartRefTick),
            .deMode    (pins.deJumper[p]),
            .txd       (pins.uartTxd[p]),
            .rts       (pins.uartRts[p]),
            .holdTicks (autoHoldTicks),
            .drvEn     (drvEn[p]),
            .rxMask    (rxMask[p])
        );
    end

    // Data and its enable are registered together so the line never sees a bit
    // before the driver turns on.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            lineTxOut <= '1;
            lineTxOe  <= '0;
            uartRxd   <= '1;
        end else begin
            lineTxOut <= pins.uartTxd;
            lineTxOe  <= drvEn;
            uartRxd   <= pins.lineRxd | rxMask;
        end
    end

endmodule : qsp_card

// [verif/qsp_card_properties.sv]
// Port checker for the quad serial port glue, bound into qsp_card.
// Assumes each checked pin passes two sync flops and one output register.
`timescale 1ns/1ps
`include "qsp_defines.svh"

module qsp_card_properties
    import qsp_pkg::*;
(
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic [9:0] ioAddr,
    input wire logic       ioAen,
    input wire logic       ioRdN,
    input wire logic       ioWrN,
    input wire logic       speed_switch_bank,
    input wire logic [1:0] mode_switch_bank,
    input wire logic [4:0] baseAddrSwitch,
    input wire logic [1:0] port1_driver_enable_jumper,
    input wire logic [1:0] port2_driver_enable_jumper,
    input wire logic [1:0] port3_driver_enable_jumper,
    input wire logic [1:0] port4_driver_enable_jumper,
    input wire logic [3:0] uartTxd,
    input wire logic [3:0] uartRts,
    input wire logic [3:0] uartSel,
    input wire logic       uartRdStb,
    input wire logic       uartWrStb,
    input wire logic       cardHit,
    input wire logic       uartRefTick,
    input wire logic [3:0] lineTxOe,
    input wire logic [3:0] uartRxd
);
    localparam qsp_pins_t IDLE = {10'h3ff, 51'h0};
    localparam logic [3:0][9:0] LEG = {`QSP_LEGACY_BASE4, `QSP_LEGACY_BASE3,
                                       `QSP_LEGACY_BASE2, `QSP_LEGACY_BASE1};
    qsp_pins_t  p0, p1, p2, p3;
    logic [9:0] relOfs;
    logic [3:0] expSel;
    logic [7:0] gap;
    logic [7:0] spdAge;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // Mirrors the synchroniser so p3 is the pin state behind the current outputs.
    assign p0 = {ioRdN, ioWrN, uartTxd, 4'hf, ioAen, ioAddr, uartRts, speed_switch_bank,
                 mode_switch_bank, baseAddrSwitch, port4_driver_enable_jumper,
                 port3_driver_enable_jumper, port2_driver_enable_jumper,
                 port1_driver_enable_jumper, 20'h0};
    assign relOfs = p3.ioAddr - {1'b1, ~p3.baseSwitch[4], ~p3.baseSwitch[3:0], 4'h0};

    always_ff @(posedge clk) begin
        if (!nrst) begin
            {p1, p2, p3} <= {IDLE, IDLE, IDLE};
            gap          <= 8'h00;
            spdAge       <= 8'h00;
        end else begin
            {p1, p2, p3} <= {p0, p1, p2};
            gap          <= uartRefTick ? 8'h01 : gap + {7'h00, gap != 8'hff};
            spdAge       <= (p2.speedSwitch != p3.speedSwitch) ? 8'h00
                                                               : spdAge + {7'h00, spdAge != 8'hff};
        end
    end

    for (genvar i = 0; i < 4; i++) begin : g_port
        assign expSel[i] = !p3.ioAen && (p3.ioRdN ^ p3.ioWrN) && (p3.modeSwitch[1] ?
                           p3.ioAddr[9:3] == LEG[i][9:3] : relOfs[9:3] == 7'(i));
        property p_oe_fixed;
            p3.deJumper[i] != QSP_DE_AUTO |->
            lineTxOe[i] == (p3.deJumper[i] == QSP_DE_ON ||
                            (p3.deJumper[i] == QSP_DE_RTS && p3.uartRts[i]));
        endproperty
        a_oe_fixed: assert property (p_oe_fixed) else $error("fixed mode enable wrong");
        property p_auto_on;
            p3.deJumper[i] == QSP_DE_AUTO && !p3.uartTxd[i] ##1 p3.deJumper[i] == QSP_DE_AUTO
            |-> lineTxOe[i];
        endproperty
        a_auto_on: assert property (p_auto_on) else $error("auto driver not on");
        property p_rx_mask;
            lineTxOe[i] && p3.deJumper[i] != QSP_DE_ON |-> uartRxd[i];
        endproperty
        a_rx_mask: assert property (p_rx_mask) else $error("receive not masked");
    end

    property p_sel; uartSel == expSel; endproperty
    a_sel: assert property (p_sel) else $error("chip select wrong");
    property p_hit; cardHit == |expSel; endproperty
    a_hit: assert property (p_hit) else $error("card hit wrong");
    property p_strobe;
        {uartRdStb, uartWrStb} == ({2{cardHit}} & ~{p3.ioRdN, p3.ioWrN});
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe wrong");
    property p_tick_pulse; uartRefTick |=> !uartRefTick; endproperty
    a_tick_pulse: assert property (p_tick_pulse) else $error("tick too long");
    property p_tick_gap;
        uartRefTick && spdAge == 8'hff |->
        (p3.speedSwitch ? gap inside {8'h08, 8'h09} : gap inside {8'h43, 8'h44});
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("tick spacing wrong");
endmodule : qsp_card_properties

bind qsp_card qsp_card_properties u_props (.*);

// [verif/qsp_line_partner.sv]
// Far end of the pairs: a remote talker on port 1; released pairs bias high.
// Assumes go is a one-cycle pulse given while busy is low.
`timescale 1ns/1ps

module qsp_line_partner #(
    parameter int BIT = 16
)
(
    input  wire logic       clk,
    input  wire logic [3:0] txOut,
    input  wire logic [3:0] txOe,
    input  wire logic       go,
    input  wire logic [7:0] data,
    output logic            busy,
    output logic            clash,
    output logic [3:0]      rxd
);
    logic [9:0] frame = 10'h3ff;
    int         left  = 0;

    assign busy  = left > 0;
    // Flags the remote talking while the card holds the shared pair.
    assign clash = busy && txOe[0];
    for (genvar i = 0; i < 4; i++) begin : g_pair
        assign rxd[i] = txOe[i] ? txOut[i]
                      : (i == 0 && busy) ? frame[(10 * BIT - left) / BIT] : 1'b1;
    end
    always @(posedge clk) begin
        if (go && !busy) begin
            frame <= {1'b1, data, 1'b0};
            left  <= 10 * BIT;
        end else if (busy) begin
            left <= left - 1;
        end
    end
endmodule : qsp_line_partner

// [verif/qsp_card_test.sv]
// Self-checking bench for qsp_card: decode, interrupt routing, reference tick, drivers.
// Assumes the bound port checker and the line partner model.
`timescale 1ns/1ps
`include "qsp_defines.svh"

module qsp_card_test
    import qsp_pkg::*;
;
    localparam int BIT = 16;
    logic            clk = 0, nrst = 0, ioAen = 0, ioRdN = 1, ioWrN = 1, speed_switch_bank = 1;
    logic            uartRdStb, uartWrStb, cardHit, uartRefTick, go = 0, busy, clash;
    logic [9:0]      ioAddr = '0;
    logic [1:0]      mode_switch_bank = '0;
    logic [4:0]      baseAddrSwitch = '0;
    logic [3:0][1:0] jmp = '0;
    logic [3:0][3:0] isel = '0;
    logic [15:0]     autoHoldTicks = 16'h0014;
    logic [15:0]     irqOut;
    logic [3:0]      uartTxd = '1, uartRts = '0, uartIrq = '0;
    logic [3:0]      lineRxd, uartSel, lineTxOut, lineTxOe, uartRxd;
    logic [7:0]      rdata = '0;
    int              err_total = 0, tests_run = 0, cycles = 0, hiRun = 0;
    int              legb[4] = '{`QSP_LEGACY_BASE1, `QSP_LEGACY_BASE2, `QSP_LEGACY_BASE3,
                                 `QSP_LEGACY_BASE4};

    qsp_card dut (.*, .port1_driver_enable_jumper(jmp[0]),
        .port2_driver_enable_jumper(jmp[1]), .port3_driver_enable_jumper(jmp[2]),
        .port4_driver_enable_jumper(jmp[3]), .port1_irq_line_select(isel[0]),
        .port2_irq_line_select(isel[1]), .port3_irq_line_select(isel[2]),
        .port4_irq_line_select(isel[3]));
    qsp_line_partner #(.BIT(BIT)) u_line (.clk, .txOut(lineTxOut), .txOe(lineTxOe), .go,
        .data(rdata), .busy, .clash, .rxd(lineRxd));

    always #4 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            err_total++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (err_total == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t %s: %h != %h", $time, what, got, exp);
        end
    endtask : chk

    function automatic int rel_base();
        return 'h200 + (baseAddrSwitch[4] ? 0 : 'h100) + (15 - baseAddrSwitch[3:0]) * 'h10;
    endfunction : rel_base

    task automatic bus(input logic [9:0] a, input logic aen, input logic [1:0] rw);
        logic [3:0] e;
        int         b;
        ioAddr = a;
        ioAen  = aen;
        {ioRdN, ioWrN} = rw;
        repeat (3) @(negedge clk);
        for (int p = 0; p < 4; p++) begin
            b = mode_switch_bank[1] ? legb[p] : rel_base() + 8 * p;
            e[p] = !aen && (rw[1] != rw[0]) && 10'(a - 10'(b)) < 10'h8;
        end
        chk(uartSel, e, "select");
        chk({cardHit, uartRdStb, uartWrStb}, {|e, |e & !rw[1], |e & !rw[0]}, "strobes");
        {ioRdN, ioWrN} = 2'b11;
        repeat (3) @(negedge clk);
    endtask : bus

    task automatic send(input logic [7:0] d);
        for (int i = 0; i < 10 * BIT; i++) begin
            uartTxd[0] = (i < BIT) ? 1'b0 : (i >= 9 * BIT) ? 1'b1 : d[i / BIT - 1];
            @(negedge clk);
            hiRun = uartTxd[0] ? hiRun + 1 : 0;
            if (i >= 4) chk({lineTxOe[0], uartRxd[0], clash}, 3'b110, "auto drive");
            if (i % BIT == BIT / 2) chk(lineTxOut[0], uartTxd[0], "line data");
        end
    endtask : send

    initial begin
        int          n, a, rb;
        longint      en;
        logic [15:0] e16;
        logic        q[$];
        void'($urandom(40426));
        repeat (10) @(negedge clk);
        nrst = 1;
        for (int m = 0; m < 2; m++) begin
            mode_switch_bank[1] = m[0];
            baseAddrSwitch      = 5'($urandom);
            repeat (3) @(negedge clk);
            rb = rel_base();
            for (int k = 0; k < 16; k++) begin
                a = m ? legb[k % 4] : rb + 8 * (k % 4);
                bus(10'(a + $urandom % 8), 1'b0, ($urandom % 2) ? 2'b01 : 2'b10);
            end
            bus(10'(a), 1'b1, 2'b01);
            bus(10'(a), 1'b0, 2'b00);
            bus(m ? 10'h3f0 : 10'(rb - 1), 1'b0, 2'b01);
            bus(m ? 10'h2e0 : 10'(rb + 'h20), 1'b0, 2'b10);
        end
        for (int m = 0; m < 2; m++) begin
            mode_switch_bank[0] = m[0];
            isel = 16'($urandom);
            for (int p = 0; p < 5; p++) begin
                uartIrq = (p < 4) ? 4'(1 << p) : 4'hf;
                repeat (3) @(negedge clk);
                e16 = '0;
                for (int r = 0; r < 4; r++) begin
                    if (uartIrq[r]) e16[m ? isel[0] : isel[r]] = 1'b1;
                end
                chk(irqOut, e16, "irq routing");
            end
            uartIrq = '0;
        end
        for (int s = 0; s < 2; s++) begin
            speed_switch_bank = s[0];
            repeat (200) @(negedge clk);
            n = 0;
            repeat (20000) begin
                @(negedge clk);
                n += int'(uartRefTick);
            end
            en = 20000 * (s ? 64'd14745600 : 64'd1843200) / 125000000;
            chk(16'(n >= en - 1 && n <= en + 1), 16'h0001, "tick rate");
        end
        for (int r = 0; r < 4; r++) begin
            for (int p = 0; p < 4; p++) begin
                jmp[p] = 2'((p + r) % 4);
            end
            repeat (2) begin
                uartRts = 4'($urandom);
                uartTxd = 4'($urandom);
                repeat (4) @(negedge clk);
                for (int p = 0; p < 4; p++) begin
                    if (jmp[p] == QSP_DE_RTS) chk(lineTxOe[p], uartRts[p], "rts mode");
                    if (jmp[p] == QSP_DE_ON) chk(lineTxOe[p], 1'b1, "on mode");
                    if (jmp[p] == 2'h3) chk(lineTxOe[p], 1'b0, "no driver");
                end
            end
        end
        jmp     = '0;
        uartTxd = '1;
        repeat (60) @(negedge clk);
        send(8'($urandom));
        send(8'($urandom));
        n = 0;
        while (lineTxOe[0] === 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        chk(16'(n >= 162 - hiRun && n <= 178 - hiRun), 16'h0001, "auto release");
        rdata = 8'($urandom);
        for (int i = 0; i < 10; i++) begin
            q.push_back(i == 0 ? 1'b0 : i == 9 ? 1'b1 : rdata[i - 1]);
        end
        go = 1;
        @(negedge clk);
        go = 0;
        for (int i = 1; i < 10 * BIT; i++) begin
            @(negedge clk);
            if (i % BIT == BIT / 2) chk({uartRxd[0], lineTxOe[0]}, {q.pop_front(), 1'b0}, "rx");
        end
        complete_run();
    end
endmodule : qsp_card_test
